// ---- pkg/servo_seq_pkg.sv ----
`default_nettype none
package servo_seq_pkg;

  // register bus shape
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // register offsets (word index on the plain port)
  localparam logic [4:0] OFF_ROT_SPEED    = 5'h00;
  localparam logic [4:0] OFF_CONF_WIDTH   = 5'h01;
  localparam logic [4:0] OFF_BRAKE_DLY1   = 5'h02;
  localparam logic [4:0] OFF_BRAKE_SPEED  = 5'h03;
  localparam logic [4:0] OFF_BRAKE_DLY2   = 5'h04;
  localparam logic [4:0] OFF_HOLD_TIME    = 5'h05;
  localparam logic [4:0] OFF_IN_SEL_ONE   = 5'h06;
  localparam logic [4:0] OFF_IN_SEL_TWO   = 5'h07;
  localparam logic [4:0] OFF_IN_SEL_FIVE  = 5'h08;
  localparam logic [4:0] OFF_OUT_SEL_ONE  = 5'h09;
  localparam logic [4:0] OFF_OUT_SEL_TWO  = 5'h0a;
  localparam logic [4:0] OFF_OUT_SEL_THR  = 5'h0b;
  localparam logic [4:0] OFF_OUT_INVERT   = 5'h0c;
  localparam logic [4:0] OFF_WARN_PCT     = 5'h0d;
  localparam logic [4:0] OFF_OVF_LEVEL    = 5'h0e;
  localparam logic [4:0] OFF_STATUS       = 5'h0f;

  // reset values of the settings
  localparam logic [13:0] RST_ROT_SPEED   = 14'h0014;
  localparam logic [6:0]  RST_CONF_WIDTH  = 7'h0a;
  localparam logic [5:0]  RST_BRAKE_DLY1  = 6'h00;
  localparam logic [13:0] RST_BRAKE_SPEED = 14'h0064;
  localparam logic [6:0]  RST_BRAKE_DLY2  = 7'h32;
  localparam logic [9:0]  RST_HOLD_TIME   = 10'h014;
  localparam logic [15:0] RST_IN_SEL_ONE  = 16'h1881;
  localparam logic [15:0] RST_IN_SEL_TWO  = 16'h8882;
  localparam logic [15:0] RST_IN_SEL_FIVE = 16'h6543;
  localparam logic [15:0] RST_OUT_SEL_ONE = 16'h0000;
  localparam logic [15:0] RST_OUT_SEL_TWO = 16'h0100;
  localparam logic [15:0] RST_OUT_SEL_THR = 16'h0000;
  localparam logic [15:0] RST_OUT_INVERT  = 16'h0000;
  localparam logic [6:0]  RST_WARN_PCT    = 7'h64;
  localparam logic [29:0] RST_OVF_LEVEL   = 30'h0004_0000;

  // percent scale of the warning level
  localparam logic [39:0] PCT_SCALE = 40'h00_0000_0064;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] BRAKE_STEP_MS = 4'ha;

  // stop sequence, gray along off -> run -> wait -> decel
  typedef enum logic [1:0] {
    ST_OFF        = 2'b00,
    ST_RUN        = 2'b01,
    ST_BRAKE_WAIT = 2'b11,
    ST_DECEL      = 2'b10
  } seq_state_t;

endpackage
`default_nettype wire

// ---- rtl/servo_sequence_monitor.sv ----
// Contract
// RULE1 - rotation flag when speed above threshold
// RULE2 - speed conformity within width in speed control
// RULE3 - first brake delay, 10 ms steps
// RULE4 - brake command speed threshold setting
// RULE5 - second brake delay, 10 ms steps
// RULE6 - stopped: brake off, delay, then servo off
// RULE7 - rotating stop: brake off below speed
// RULE8 - supply dip suppresses alarms for hold time
// RULE9 - undervoltage or control loss forces servo off (the code takes undervoltage only while a dip is held)
// RULE10 - deviation warning at percent of level
// RULE11 - deviation overflow level setting
// RULE12 - deviation overflow alarm in position control
// RULE13 - input allocation applies after restart only
// RULE14 - output allocation applies after restart only
// RULE15 - route rotation and conformity by selection one
// RULE16 - route brake output by selection two
// RULE17 - second delay also ends brake hold
// RULE18 - host leaves reserved settings at defaults
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module servo_sequence_monitor #(
  parameter int unsigned MS_CYCLES = servo_seq_pkg::MS_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic [4:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  input  wire logic               run_cmd,
  input  wire logic               main_power_lost,
  input  wire logic               control_power_low,
  input  wire logic               undervoltage_alarm,
  input  wire logic               servo_alarm_in,
  input  wire logic               position_mode,
  input  wire logic               power_restart,
  input  wire logic signed [15:0] motor_speed,
  input  wire logic signed [15:0] speed_cmd,
  input  wire logic signed [31:0] deviation_count,
  output logic                    servo_on,
  output logic                    brake_interlock_out,
  output logic                    rotation_detected,
  output logic                    speed_conformity,
  output logic                    deviation_warning,
  output logic                    deviation_alarm,
  output logic                    alarm_suppressed,
  output logic      [2:0]         terminal_out,
  output logic      [47:0]        input_alloc
);

  localparam int PINS = 4;

  // settings as stored by software
  logic [13:0] rotation_detect_speed;
  logic [6:0]  speed_conformity_width;
  logic [5:0]  brake_delay_first;
  logic [13:0] brake_command_speed;
  logic [6:0]  brake_delay_second;
  logic [9:0]  momentary_hold_time;
  logic [15:0] input_select_one;
  logic [15:0] input_select_two;
  logic [15:0] input_select_five;
  logic [15:0] output_select_one;
  logic [15:0] output_select_two;
  logic [15:0] output_select_three;
  logic [15:0] output_polarity_invert;
  logic [6:0]  deviation_warning_percent;
  logic [29:0] deviation_overflow_level;

  // allocation copies in force since the last restart
  logic [15:0] act_out_one;
  logic [15:0] act_out_two;
  logic [15:0] act_out_three;
  logic [15:0] act_invert;

  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_s1;
  logic [PINS-1:0] pin_s2;
  logic [PINS-1:0] pin_s3;
  logic [PINS-1:0] pin_f;
  logic run_f;
  logic main_lost_f;
  logic ctrl_low_f;
  logic uv_f;

  servo_seq_pkg::seq_state_t state;
  servo_seq_pkg::seq_state_t next_state;
  logic [31:0] seq_pre;
  logic [10:0] seq_ms;
  logic [31:0] dip_pre;
  logic [10:0] dip_ms;
  logic        dip_active;
  logic        dip_expired;
  logic        power_fail;
  logic        alarm_det;
  logic        fault;

  logic [16:0] speed_abs;
  logic [16:0] speed_err;
  logic [16:0] err_abs;
  logic [32:0] dev_abs;
  logic [39:0] dev_scaled;
  logic [39:0] warn_level;
  logic [10:0] delay1_ms;
  logic [10:0] delay2_ms;
  logic [31:0] ms_last;

  // true when an allocation digit selects terminal t
  function automatic logic digit_hits(input logic [3:0] digit,
                                      input int         t);
    return digit == 4'(t + 1);
  endfunction

  // pin filter: three stages, change taken once stages two and three agree
  assign pin_raw = {undervoltage_alarm, control_power_low,
                    main_power_lost, run_cmd};
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        pin_f[i] <= 1'b0;
      end else if (pin_s2[i] == pin_s3[i]) begin
        pin_f[i] <= pin_s3[i];
      end
    end
  end

  assign run_f       = pin_f[0];
  assign main_lost_f = pin_f[1];
  assign ctrl_low_f  = pin_f[2];
  assign uv_f        = pin_f[3];

  // register writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rotation_detect_speed     <= servo_seq_pkg::RST_ROT_SPEED; // RULE1
      speed_conformity_width    <= servo_seq_pkg::RST_CONF_WIDTH; // RULE2
      brake_delay_first         <= servo_seq_pkg::RST_BRAKE_DLY1; // RULE3
      brake_command_speed       <= servo_seq_pkg::RST_BRAKE_SPEED; // RULE4
      brake_delay_second        <= servo_seq_pkg::RST_BRAKE_DLY2; // RULE5
      momentary_hold_time       <= servo_seq_pkg::RST_HOLD_TIME; // RULE8
      input_select_one          <= servo_seq_pkg::RST_IN_SEL_ONE;
      input_select_two          <= servo_seq_pkg::RST_IN_SEL_TWO;
      input_select_five         <= servo_seq_pkg::RST_IN_SEL_FIVE;
      output_select_one         <= servo_seq_pkg::RST_OUT_SEL_ONE;
      output_select_two         <= servo_seq_pkg::RST_OUT_SEL_TWO;
      output_select_three       <= servo_seq_pkg::RST_OUT_SEL_THR;
      output_polarity_invert    <= servo_seq_pkg::RST_OUT_INVERT;
      deviation_warning_percent <= servo_seq_pkg::RST_WARN_PCT; // RULE10
      deviation_overflow_level  <= servo_seq_pkg::RST_OVF_LEVEL; // RULE11
    end else if (reg_wr) begin
      case (reg_addr)
        servo_seq_pkg::OFF_ROT_SPEED:   rotation_detect_speed <= reg_wdata[13:0];
        servo_seq_pkg::OFF_CONF_WIDTH:  speed_conformity_width <= reg_wdata[6:0];
        servo_seq_pkg::OFF_BRAKE_DLY1:  brake_delay_first <= reg_wdata[5:0];
        servo_seq_pkg::OFF_BRAKE_SPEED: brake_command_speed <= reg_wdata[13:0];
        servo_seq_pkg::OFF_BRAKE_DLY2:  brake_delay_second <= reg_wdata[6:0];
        servo_seq_pkg::OFF_HOLD_TIME:   momentary_hold_time <= reg_wdata[9:0];
        servo_seq_pkg::OFF_IN_SEL_ONE:  input_select_one <= reg_wdata[15:0];
        servo_seq_pkg::OFF_IN_SEL_TWO:  input_select_two <= reg_wdata[15:0];
        servo_seq_pkg::OFF_IN_SEL_FIVE: input_select_five <= reg_wdata[15:0];
        servo_seq_pkg::OFF_OUT_SEL_ONE: output_select_one <= reg_wdata[15:0];
        servo_seq_pkg::OFF_OUT_SEL_TWO: output_select_two <= reg_wdata[15:0];
        servo_seq_pkg::OFF_OUT_SEL_THR: output_select_three <= reg_wdata[15:0];
        servo_seq_pkg::OFF_OUT_INVERT:  output_polarity_invert <= reg_wdata[15:0];
        servo_seq_pkg::OFF_WARN_PCT:    deviation_warning_percent <= reg_wdata[6:0];
        servo_seq_pkg::OFF_OVF_LEVEL:   deviation_overflow_level <= reg_wdata[29:0];
        default: ;
      endcase
    end
  end

  // allocation copies change only on a drive restart
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      input_alloc   <= {servo_seq_pkg::RST_IN_SEL_FIVE,
                        servo_seq_pkg::RST_IN_SEL_TWO,
                        servo_seq_pkg::RST_IN_SEL_ONE}; // RULE13
      act_out_one   <= servo_seq_pkg::RST_OUT_SEL_ONE; // RULE14
      act_out_two   <= servo_seq_pkg::RST_OUT_SEL_TWO;
      act_out_three <= servo_seq_pkg::RST_OUT_SEL_THR;
      act_invert    <= servo_seq_pkg::RST_OUT_INVERT;
    end else if (power_restart) begin
      input_alloc   <= {input_select_five, input_select_two,
                        input_select_one}; // RULE13
      act_out_one   <= output_select_one; // RULE14
      act_out_two   <= output_select_two;
      act_out_three <= output_select_three;
      act_invert    <= output_polarity_invert;
    end
  end

  // speed and deviation magnitudes
  always_comb begin
    speed_abs  = motor_speed[15] ? 17'(-$signed({motor_speed[15], motor_speed}))
                                 : {1'b0, motor_speed};
    speed_err  = 17'($signed({speed_cmd[15], speed_cmd})
                   - $signed({motor_speed[15], motor_speed}));
    err_abs    = speed_err[16] ? 17'(-$signed(speed_err)) : speed_err;
    dev_abs    = deviation_count[31]
               ? 33'(-$signed({deviation_count[31], deviation_count}))
               : {1'b0, deviation_count};
    dev_scaled = 40'(dev_abs) * servo_seq_pkg::PCT_SCALE;
    warn_level = 40'(deviation_overflow_level)
               * 40'(deviation_warning_percent);
    delay1_ms  = 11'(brake_delay_first) * 11'(servo_seq_pkg::BRAKE_STEP_MS);
    delay2_ms  = 11'(brake_delay_second) * 11'(servo_seq_pkg::BRAKE_STEP_MS);
  end

  // status flags from speed and deviation
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rotation_detected <= 1'b0;
      speed_conformity  <= 1'b0;
      deviation_warning <= 1'b0;
      deviation_alarm   <= 1'b0;
    end else begin
      rotation_detected <= speed_abs > 17'(rotation_detect_speed); // RULE1
      speed_conformity  <= !position_mode
                        && err_abs < 17'(speed_conformity_width); // RULE2
      deviation_warning <= position_mode && dev_scaled > warn_level; // RULE10
      deviation_alarm   <= position_mode
                        && dev_abs > 33'(deviation_overflow_level); // RULE12
    end
  end

  assign ms_last = MS_CYCLES - 32'd1;

  // supply dip watch with its own millisecond count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dip_active  <= 1'b0;
      dip_expired <= 1'b0;
      dip_pre     <= '0;
      dip_ms      <= '0;
    end else if (!main_lost_f) begin
      dip_active  <= 1'b0; // supply back: carry on
      dip_expired <= 1'b0;
      dip_pre     <= '0;
      dip_ms      <= '0;
    end else if (!dip_active && !dip_expired) begin
      dip_active <= 1'b1; // RULE8
    end else if (dip_active) begin
      if (dip_ms >= 11'(momentary_hold_time)) begin
        dip_active  <= 1'b0; // RULE8
        dip_expired <= 1'b1;
      end else if (dip_pre == ms_last) begin
        dip_pre <= '0;
        dip_ms  <= dip_ms + 11'd1;
      end else begin
        dip_pre <= dip_pre + 32'd1;
      end
    end
  end

  // alarms are not detected while a dip is being held
  assign alarm_suppressed = dip_active;
  assign alarm_det  = (servo_alarm_in || deviation_alarm) && !dip_active; // RULE8
  assign power_fail = dip_expired || (dip_active && uv_f) || ctrl_low_f; // RULE9
  assign fault      = alarm_det || power_fail;

  // stop sequencing
  always_comb begin
    next_state = state;
    case (state)
      servo_seq_pkg::ST_OFF: begin
        if (run_f && !fault) begin
          next_state = servo_seq_pkg::ST_RUN;
        end
      end
      servo_seq_pkg::ST_RUN: begin
        if (fault || !rotation_detected) begin
          if (fault || !run_f) begin
            next_state = fault ? servo_seq_pkg::ST_DECEL
                               : servo_seq_pkg::ST_BRAKE_WAIT; // RULE6
          end
        end else if (!run_f) begin
          next_state = servo_seq_pkg::ST_DECEL; // RULE7
        end
      end
      servo_seq_pkg::ST_BRAKE_WAIT: begin
        if (fault || seq_ms >= delay1_ms) begin
          next_state = servo_seq_pkg::ST_OFF; // RULE3 RULE6
        end
      end
      servo_seq_pkg::ST_DECEL: begin
        if (speed_abs < 17'(brake_command_speed) // RULE4 RULE7
            || seq_ms >= delay2_ms) begin // RULE5 RULE17
          next_state = servo_seq_pkg::ST_OFF;
        end
      end
      default: next_state = servo_seq_pkg::ST_OFF;
    endcase
  end

  // state, outputs and time in state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state               <= servo_seq_pkg::ST_OFF;
      servo_on            <= 1'b0;
      brake_interlock_out <= 1'b0;
      seq_pre             <= '0;
      seq_ms              <= '0;
    end else begin
      state    <= next_state;
      servo_on <= next_state == servo_seq_pkg::ST_RUN
               || next_state == servo_seq_pkg::ST_BRAKE_WAIT; // RULE6
      brake_interlock_out <= next_state == servo_seq_pkg::ST_RUN
                          || next_state == servo_seq_pkg::ST_DECEL; // RULE7
      if (next_state != state) begin
        seq_pre <= '0;
        seq_ms  <= '0;
      end else if (seq_pre == ms_last) begin
        seq_pre <= '0;
        seq_ms  <= (seq_ms == 11'h7ff) ? seq_ms : seq_ms + 11'd1;
      end else begin
        seq_pre <= seq_pre + 32'd1;
      end
    end
  end

  // terminal routing with polarity
  for (genvar t = 0; t < 3; t++) begin : g_term
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        terminal_out[t] <= 1'b0;
      end else begin
        terminal_out[t] <=
          ((digit_hits(act_out_one[11:8], t) && rotation_detected) // RULE15
        || (digit_hits(act_out_one[7:4], t) && speed_conformity) // RULE15
        || (digit_hits(act_out_two[11:8], t) && brake_interlock_out)) // RULE16
         ^ (act_invert[4*t +: 4] != 4'h0);
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        servo_seq_pkg::OFF_ROT_SPEED:   reg_rdata <= 32'(rotation_detect_speed);
        servo_seq_pkg::OFF_CONF_WIDTH:  reg_rdata <= 32'(speed_conformity_width);
        servo_seq_pkg::OFF_BRAKE_DLY1:  reg_rdata <= 32'(brake_delay_first);
        servo_seq_pkg::OFF_BRAKE_SPEED: reg_rdata <= 32'(brake_command_speed);
        servo_seq_pkg::OFF_BRAKE_DLY2:  reg_rdata <= 32'(brake_delay_second);
        servo_seq_pkg::OFF_HOLD_TIME:   reg_rdata <= 32'(momentary_hold_time);
        servo_seq_pkg::OFF_IN_SEL_ONE:  reg_rdata <= 32'(input_select_one);
        servo_seq_pkg::OFF_IN_SEL_TWO:  reg_rdata <= 32'(input_select_two);
        servo_seq_pkg::OFF_IN_SEL_FIVE: reg_rdata <= 32'(input_select_five);
        servo_seq_pkg::OFF_OUT_SEL_ONE: reg_rdata <= 32'(output_select_one);
        servo_seq_pkg::OFF_OUT_SEL_TWO: reg_rdata <= 32'(output_select_two);
        servo_seq_pkg::OFF_OUT_SEL_THR: reg_rdata <= 32'(output_select_three);
        servo_seq_pkg::OFF_OUT_INVERT:  reg_rdata <= 32'(output_polarity_invert);
        servo_seq_pkg::OFF_WARN_PCT:    reg_rdata <= 32'(deviation_warning_percent);
        servo_seq_pkg::OFF_OVF_LEVEL:   reg_rdata <= 32'(deviation_overflow_level);
        servo_seq_pkg::OFF_STATUS: reg_rdata <= {20'h00000, state, dip_expired,
            dip_active, power_fail, alarm_det, deviation_alarm,
            deviation_warning, speed_conformity, rotation_detected,
            brake_interlock_out, servo_on};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  rotation_flag_a: assert property ( // RULE1
    rotation_detected == $past(speed_abs > 17'(rotation_detect_speed)))
    else $error("rotation flag does not follow speed");
  conform_mode_a: assert property ( // RULE2
    $past(position_mode) |-> !speed_conformity)
    else $error("conformity raised in position control");
  brake_first_a: assert property ( // RULE6
    state == servo_seq_pkg::ST_BRAKE_WAIT |-> servo_on && !brake_interlock_out)
    else $error("servo off before brake released");
  decel_servo_a: assert property ( // RULE7
    state == servo_seq_pkg::ST_DECEL |-> !servo_on && brake_interlock_out)
    else $error("coast stop outputs wrong");
  brake_speed_a: assert property ( // RULE4
    (state == servo_seq_pkg::ST_DECEL
     && speed_abs < 17'(brake_command_speed)) |=> !brake_interlock_out)
    else $error("brake not dropped below command speed");
  dip_hold_a: assert property ( // RULE8
    (dip_active && main_lost_f && dip_ms < 11'(momentary_hold_time))
    |=> dip_active)
    else $error("dip hold ended too early");
  dip_force_off_a: assert property ( // RULE9
    (dip_active && uv_f) |=> !servo_on)
    else $error("servo kept on after undervoltage in dip");
  dev_alarm_a: assert property ( // RULE12
    (position_mode && dev_abs > 33'(deviation_overflow_level))
    |=> deviation_alarm)
    else $error("overflow alarm missing");
  dev_warn_a: assert property ( // RULE10
    (!position_mode || dev_scaled <= warn_level) |=> !deviation_warning)
    else $error("warning without excess deviation");
  restart_only_a: assert property ( // RULE14
    !$past(power_restart) |-> $stable(act_out_two))
    else $error("allocation changed without restart");

endmodule // servo_sequence_monitor
`default_nettype wire

// ---- dv/motor_load_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module motor_load_model (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               servo_on,
  input  wire logic signed [15:0] target_speed,
  output logic signed [15:0]      motor_speed
);
  // follows target while energised, coasts 5 r/min a cycle when off
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      motor_speed <= 16'sh0000;
    else if (servo_on)
      motor_speed <= target_speed;
    else if (motor_speed > 16'sh0005)
      motor_speed <= motor_speed - 16'sh0005;
    else
      motor_speed <= 16'sh0000;
  end
endmodule // motor_load_model
`default_nettype wire

// ---- dv/servo_sequence_monitor_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module servo_sequence_monitor_test;
  logic               core_clk = 1'b0;
  logic               resetn = 1'b0;
  logic        [4:0]  reg_addr = 5'h00;
  logic        [31:0] reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic        [31:0] reg_rdata;
  logic               run_cmd = 1'b0;
  logic               main_power_lost = 1'b0;
  logic               control_power_low = 1'b0;
  logic               undervoltage_alarm = 1'b0;
  logic               servo_alarm_in = 1'b0;
  logic               position_mode = 1'b0;
  logic               power_restart = 1'b0;
  logic signed [15:0] target = 16'sh0000;
  logic signed [15:0] motor_speed;
  logic signed [15:0] speed_cmd = 16'sh0000;
  logic signed [31:0] deviation_count = 32'sh0;
  logic               servo_on, brake_interlock_out, rotation_detected;
  logic               speed_conformity, deviation_warning;
  logic               deviation_alarm, alarm_suppressed;
  logic        [2:0]  terminal_out;
  logic        [47:0] input_alloc;
  int                 err_count = 0;
  int                 comparisons = 0;
  int                 cycles = 0;

  servo_sequence_monitor #(.MS_CYCLES(10)) servo_sequence_monitor_inst (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .run_cmd, .main_power_lost, .control_power_low,
    .undervoltage_alarm, .servo_alarm_in, .position_mode, .power_restart,
    .motor_speed, .speed_cmd, .deviation_count, .servo_on,
    .brake_interlock_out, .rotation_detected, .speed_conformity,
    .deviation_warning, .deviation_alarm, .alarm_suppressed,
    .terminal_out, .input_alloc);

  motor_load_model motor_load_model_inst (
    .core_clk, .resetn, .servo_on, .target_speed(target), .motor_speed);

  // 100 MHz clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(48'(reg_rdata), 48'(exp));
  endtask

  // main sequence, settings left at defaults unless in range
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    cyc(2);
    chk(input_alloc, 48'h6543_8882_1881);
    rd(servo_seq_pkg::OFF_OVF_LEVEL, 32'h0004_0000);
    rd(servo_seq_pkg::OFF_BRAKE_SPEED, 32'h64);
    rd(servo_seq_pkg::OFF_BRAKE_DLY2, 32'h32);
    rd(servo_seq_pkg::OFF_CONF_WIDTH, 32'ha);
    rd(5'h1f, 32'h0);
    wr(servo_seq_pkg::OFF_IN_SEL_ONE, 32'h1234);
    wr(servo_seq_pkg::OFF_OUT_SEL_ONE, 32'h0230);
    cyc(3);
    chk(input_alloc, 48'h6543_8882_1881);
    power_restart <= 1'b1;
    cyc(1);
    power_restart <= 1'b0;
    cyc(3);
    chk(input_alloc, 48'h6543_8882_1234);
    wr(servo_seq_pkg::OFF_ROT_SPEED, 32'h64);
    run_cmd <= 1'b1;
    target <= 16'sh0065;
    cyc(10);
    chk(48'(terminal_out), 48'h3);
    chk(48'(rotation_detected), 48'h1);
    // polarity stored now only takes effect after a restart
    wr(servo_seq_pkg::OFF_OUT_INVERT, 32'h0010);
    cyc(1);
    chk(48'(terminal_out), 48'h3);
    target <= 16'sh0064;
    cyc(4);
    chk(48'(rotation_detected), 48'h0);
    speed_cmd <= 16'sh01f4;
    target <= 16'sh01f9;
    cyc(4);
    chk(48'(speed_conformity), 48'h1);
    chk(48'(terminal_out), 48'h7);
    target <= 16'sh01fe;
    cyc(4);
    chk(48'(speed_conformity), 48'h0);
    main_power_lost <= 1'b1;
    cyc(50);
    chk({alarm_suppressed, servo_on}, 48'h3);
    main_power_lost <= 1'b0;
    cyc(8);
    chk({alarm_suppressed, servo_on}, 48'h1);
    main_power_lost <= 1'b1;
    cyc(10);
    undervoltage_alarm <= 1'b1;
    cyc(8);
    chk(48'(servo_on), 48'h0);
    {main_power_lost, undervoltage_alarm, run_cmd} <= 3'h0;
    cyc(150);
    run_cmd <= 1'b1;
    cyc(10);
    main_power_lost <= 1'b1;
    cyc(180);
    chk(48'(servo_on), 48'h1);
    cyc(40);
    chk(48'(servo_on), 48'h0);
    {main_power_lost, run_cmd} <= 2'h0;
    cyc(150);
    run_cmd <= 1'b1;
    target <= 16'sh03e8;
    cyc(10);
    run_cmd <= 1'b0;
    cyc(100);
    chk({servo_on, brake_interlock_out}, 48'h1);
    cyc(150);
    chk(48'(brake_interlock_out), 48'h0);
    wr(servo_seq_pkg::OFF_BRAKE_SPEED, 32'h0);
    wr(servo_seq_pkg::OFF_BRAKE_DLY2, 32'ha);
    run_cmd <= 1'b1;
    cyc(10);
    run_cmd <= 1'b0;
    cyc(950);
    chk(48'(brake_interlock_out), 48'h1);
    cyc(100);
    chk(48'(brake_interlock_out), 48'h0);
    wr(servo_seq_pkg::OFF_BRAKE_DLY1, 32'h2);
    target <= 16'sh0000;
    run_cmd <= 1'b1;
    cyc(10);
    run_cmd <= 1'b0;
    cyc(10);
    chk({servo_on, brake_interlock_out}, 48'h2);
    cyc(170);
    chk(48'(servo_on), 48'h1);
    cyc(40);
    chk(48'(servo_on), 48'h0);
    // control supply loss and an external alarm both stop the servo
    wr(servo_seq_pkg::OFF_BRAKE_SPEED, 32'h64);
    run_cmd <= 1'b1;
    cyc(10);
    control_power_low <= 1'b1;
    cyc(8);
    chk(48'(servo_on), 48'h0);
    control_power_low <= 1'b0;
    cyc(8);
    chk(48'(servo_on), 48'h1);
    servo_alarm_in <= 1'b1;
    cyc(2);
    chk(48'(servo_on), 48'h0);
    {servo_alarm_in, run_cmd} <= 2'h0;
    cyc(10);
    wr(servo_seq_pkg::OFF_WARN_PCT, 32'h32);
    wr(servo_seq_pkg::OFF_OVF_LEVEL, 32'h3e8);
    position_mode <= 1'b1;
    deviation_count <= 32'sh1f4;
    cyc(4);
    chk({deviation_alarm, deviation_warning}, 48'h0);
    deviation_count <= 32'sh1f5;
    cyc(4);
    chk({deviation_alarm, deviation_warning}, 48'h1);
    deviation_count <= 32'sh3e9;
    cyc(4);
    chk({deviation_alarm, deviation_warning}, 48'h3);
    summarize();
  end
endmodule // servo_sequence_monitor_test
`default_nettype wire
